/* File: rtl/pio_top.sv */
// Port pin logic for two ports of eight pins with peripheral overrides.
// Assumes an AHB-Lite master, a sleep controller driving sleep_clamp,
// and peripherals driving per-pin override signals synchronous to hclk.
//
// Decided for this implementation: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps
module pio_top
    import pio_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Sleep controller, shared by all ports
    input wire logic sleep_clamp,
    // Peripheral overrides, one bit per pin
    input wire logic [PIO_NPINS-1:0] pullup_override_en,
    input wire logic [PIO_NPINS-1:0] pullup_override_val,
    input wire logic [PIO_NPINS-1:0] dir_override_en,
    input wire logic [PIO_NPINS-1:0] dir_override_val,
    input wire logic [PIO_NPINS-1:0] value_override_en,
    input wire logic [PIO_NPINS-1:0] value_override_val,
    input wire logic [PIO_NPINS-1:0] toggle_override_en,
    input wire logic [PIO_NPINS-1:0] input_enable_override_en,
    input wire logic [PIO_NPINS-1:0] input_enable_override_val,
    // Alternate function inputs, unsynchronised
    output logic [PIO_NPINS-1:0] alt_digital_in,
    // External interrupt flags
    output logic [PIO_NPINS-1:0] ext_int_flag,
    // Pads
    input wire logic [PIO_NPINS-1:0] pad_in,
    output logic [PIO_NPINS-1:0] pad_out,
    output logic [PIO_NPINS-1:0] pad_oe,
    output logic [PIO_NPINS-1:0] pad_pullup
);

    // Register decode shared by the read and write paths
    function automatic pio_reg_t pio_decode(input logic [7:0] a);
        logic [7:0] rel;
        rel = {4'h0, a[3:0]};
        if (a >= PIO_OFS_CTRL) begin
            unique case (a)
                PIO_OFS_CTRL: pio_decode = PIO_REG_CTRL;
                PIO_OFS_SENSE: pio_decode = PIO_REG_SENSE;
                PIO_OFS_FLAG: pio_decode = PIO_REG_FLAG;
                default: pio_decode = PIO_REG_NONE;
            endcase
        end else begin
            unique case (rel)
                PIO_OFS_DIR: pio_decode = PIO_REG_DIR;
                PIO_OFS_OUT: pio_decode = PIO_REG_OUT;
                PIO_OFS_PIN: pio_decode = PIO_REG_PIN;
                PIO_OFS_IEN: pio_decode = PIO_REG_IEN;
                default: pio_decode = PIO_REG_NONE;
            endcase
        end
    endfunction

    // Port index within the per-port window
    function automatic logic pio_port(input logic [7:0] a);
        pio_port = (a & PIO_PORT_STRIDE) != 8'h00;
    endfunction

    // Software-visible state
    logic [PIO_NPINS-1:0] dir_bit_q;
    logic [PIO_NPINS-1:0] out_value_bit_q;
    logic [PIO_NPINS-1:0] ext_int_en_q;
    logic [2*PIO_NPINS-1:0] sense_q;
    logic global_pullup_disable_q;

    // Synchroniser and flag state
    logic [PIO_NPINS-1:0] input_sample_bit;
    logic [PIO_NPINS-1:0] flag;
    logic [PIO_NPINS-1:0] flag_clr;

    // Bus state
    logic wr_pend_q;
    logic rd_pend_q;
    logic [7:0] addr_q;
    logic hreadyout_q;
    logic [31:0] hrdata_q;

    // Per-pin combinational controls
    logic [PIO_NPINS-1:0] drv_en;
    logic [PIO_NPINS-1:0] drv_val;
    logic [PIO_NPINS-1:0] pu_en;
    logic [PIO_NPINS-1:0] in_en;
    logic [PIO_NPINS-1:0] schmitt;
    logic [PIO_NPINS-1:0] out_d;

    // Pad outputs, registered
    logic [PIO_NPINS-1:0] pad_out_q;
    logic [PIO_NPINS-1:0] pad_oe_q;
    logic [PIO_NPINS-1:0] pad_pullup_q;

    // Write path decode
    pio_reg_t wr_reg;
    logic wr_port;
    logic wr_fire;
    logic [3:0] wr_base;
    logic addr_take;

    assign addr_take = hsel & hready & (htrans == PIO_HTRANS_NONSEQ);
    assign wr_reg = pio_decode(addr_q);
    assign wr_port = pio_port(addr_q);
    assign wr_base = {wr_port, 3'b000};
    assign wr_fire = wr_pend_q & hready;

    // Address phase capture; reads get one wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 8'h00;
        end else if (rd_pend_q) begin
            rd_pend_q <= 1'b0;
        end else if (hready) begin
            wr_pend_q <= addr_take & hwrite;
            rd_pend_q <= addr_take & ~hwrite;
            if (addr_take) begin
                addr_q <= haddr[7:0];
            end
        end
    end

    // Ready and read data, sampled after any preceding write landed
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_q <= 1'b1;
            hrdata_q <= PIO_RST_RDATA;
        end else if (rd_pend_q) begin
            hreadyout_q <= 1'b1;
            hrdata_q <= PIO_RST_RDATA;
            unique case (pio_decode(addr_q))
                PIO_REG_DIR: hrdata_q[PIO_PINS-1:0] <= dir_bit_q[wr_base +: PIO_PINS];
                PIO_REG_OUT: hrdata_q[PIO_PINS-1:0] <= out_value_bit_q[wr_base +: PIO_PINS];
                PIO_REG_PIN: hrdata_q[PIO_PINS-1:0] <= input_sample_bit[wr_base +: PIO_PINS];
                PIO_REG_IEN: hrdata_q[PIO_PINS-1:0] <= ext_int_en_q[wr_base +: PIO_PINS];
                PIO_REG_CTRL: hrdata_q[PIO_CTRL_PUD_BIT] <= global_pullup_disable_q;
                PIO_REG_SENSE: hrdata_q <= sense_q;
                PIO_REG_FLAG: hrdata_q[PIO_NPINS-1:0] <= flag;
                PIO_REG_NONE: hrdata_q <= PIO_RST_RDATA;
            endcase
        end else if (addr_take & ~hwrite) begin
            hreadyout_q <= 1'b0;
        end
    end

    // Direction bits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dir_bit_q <= PIO_RST_PINS;
        end else if (wr_fire && wr_reg == PIO_REG_DIR) begin
            dir_bit_q[wr_base +: PIO_PINS] <= hwdata[PIO_PINS-1:0];
        end
    end

    // Output value bits: write, sample-bit toggle, peripheral toggle
    always_comb begin
        out_d = out_value_bit_q;
        if (wr_fire && wr_reg == PIO_REG_OUT) begin
            out_d[wr_base +: PIO_PINS] = hwdata[PIO_PINS-1:0];
        end
        if (wr_fire && wr_reg == PIO_REG_PIN) begin
            out_d[wr_base +: PIO_PINS] = out_d[wr_base +: PIO_PINS] ^ hwdata[PIO_PINS-1:0];
        end
        out_d = out_d ^ toggle_override_en;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_value_bit_q <= PIO_RST_PINS;
        end else begin
            out_value_bit_q <= out_d;
        end
    end

    // External interrupt enables and sense modes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_int_en_q <= PIO_RST_PINS;
            sense_q <= PIO_RST_SENSE;
        end else if (wr_fire) begin
            if (wr_reg == PIO_REG_IEN) begin
                ext_int_en_q[wr_base +: PIO_PINS] <= hwdata[PIO_PINS-1:0];
            end
            if (wr_reg == PIO_REG_SENSE) begin
                sense_q <= hwdata;
            end
        end
    end

    // Global pull-up disable, shared by all ports
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            global_pullup_disable_q <= 1'b0;
        end else if (wr_fire && wr_reg == PIO_REG_CTRL) begin
            global_pullup_disable_q <= hwdata[PIO_CTRL_PUD_BIT];
        end
    end

    assign flag_clr = (wr_fire && wr_reg == PIO_REG_FLAG) ? hwdata[PIO_NPINS-1:0] : PIO_RST_PINS;

    // Per-pin override muxes; peripherals own the override inputs
    genvar g;
    generate
        for (g = 0; g < PIO_NPINS; g++) begin : g_pin
            // Pull-up
            always_comb begin
                if (pullup_override_en[g]) begin
                    pu_en[g] = pullup_override_val[g];
                end else begin
                    pu_en[g] = ~dir_bit_q[g] & out_value_bit_q[g]
                        & ~global_pullup_disable_q;
                end
            end

            // Output driver enable
            always_comb begin
                if (dir_override_en[g]) begin
                    drv_en[g] = dir_override_val[g];
                end else begin
                    drv_en[g] = dir_bit_q[g];
                end
            end

            // Driven level
            always_comb begin
                if (value_override_en[g]) begin
                    drv_val[g] = value_override_val[g];
                end else begin
                    drv_val[g] = out_value_bit_q[g];
                end
            end

            // Digital input enable; enabled interrupt pins escape the clamp
            always_comb begin
                if (input_enable_override_en[g]) begin
                    in_en[g] = input_enable_override_val[g];
                end else begin
                    in_en[g] = ~(sleep_clamp & ~ext_int_en_q[g]);
                end
            end

            // Clamp to ground ahead of the Schmitt trigger
            assign schmitt[g] = pad_in[g] & in_en[g];
        end
    endgenerate

    // Alternate input straight from the Schmitt output
    assign alt_digital_in = schmitt;

    pio_sync u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .din(schmitt),
        .sample_q(input_sample_bit)
    );

    pio_edge u_edge (
        .hclk(hclk),
        .hresetn(hresetn),
        .level(input_sample_bit),
        .sense(sense_q),
        .clr(flag_clr),
        .flag_q(flag)
    );

    // Pad drive registers; reset leaves every pin floating
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pad_oe_q <= PIO_RST_PINS;
            pad_out_q <= PIO_RST_PINS;
            pad_pullup_q <= PIO_RST_PINS;
        end else begin
            pad_oe_q <= drv_en;
            pad_out_q <= drv_en & drv_val;
            pad_pullup_q <= pu_en;
        end
    end

    assign pad_oe = pad_oe_q;
    assign pad_out = pad_out_q;
    assign pad_pullup = pad_pullup_q;
    assign ext_int_flag = flag;
    assign hreadyout = hreadyout_q;
    assign hrdata = hrdata_q;
    assign hresp = PIO_HRESP_OKAY;

endmodule

/* File: rtl/pio_pkg.sv */
// Constants, register map and types for the port pin override block.
// Assumes one clock (hclk, 40 MHz) and an AHB-Lite register bus.
// Operation
// - Sleep clamp grounds digital input path
// - Enabled external interrupt pin escapes clamp
// - Clamp release sets edge flag on wake
// - No override: pull-up when dir,out,disable = 010
// - Pull-up override value alone decides pull-up
// - Driver from direction bit unless overridden
// - Direction override value switches driver
// - Driven level from value override or bit
// - Value override replaces stored output bit
// - Toggle override inverts stored output bit
// - Input enable from sleep state unless overridden
// - Input enable override value decides directly
// - Alternate input taken before synchroniser
// - Strobes per port, globals shared, overrides per pin
// - Direction bit one output, zero input
// - Input pull-up, output level from value bit
// - Writing one to sample bit toggles output
// - High-transparent latch then flop synchroniser
package pio_pkg;

    localparam int PIO_PINS = 8;
    localparam int PIO_PORTS = 2;
    localparam int PIO_NPINS = PIO_PINS * PIO_PORTS;

    localparam int PIO_CLK_PERIOD_NS = 25;

    // Register byte offsets, low address byte only
    localparam logic [7:0] PIO_PORT_STRIDE = 8'h10;
    localparam logic [7:0] PIO_OFS_DIR = 8'h00;
    localparam logic [7:0] PIO_OFS_OUT = 8'h04;
    localparam logic [7:0] PIO_OFS_PIN = 8'h08;
    localparam logic [7:0] PIO_OFS_IEN = 8'h0C;
    localparam logic [7:0] PIO_OFS_CTRL = 8'h20;
    localparam logic [7:0] PIO_OFS_SENSE = 8'h24;
    localparam logic [7:0] PIO_OFS_FLAG = 8'h28;

    // Field positions
    localparam int PIO_CTRL_PUD_BIT = 0;

    // Reset values
    localparam logic [PIO_NPINS-1:0] PIO_RST_PINS = 16'h0000;
    localparam logic [2*PIO_NPINS-1:0] PIO_RST_SENSE = 32'h0000_0000;
    localparam logic [31:0] PIO_RST_RDATA = 32'h0000_0000;

    // Sense codes, two bits per pin
    localparam logic [1:0] PIO_SENSE_LOW = 2'h0;
    localparam logic [1:0] PIO_SENSE_ANY = 2'h1;
    localparam logic [1:0] PIO_SENSE_FALL = 2'h2;
    localparam logic [1:0] PIO_SENSE_RISE = 2'h3;

    // AHB codes
    localparam logic [1:0] PIO_HTRANS_NONSEQ = 2'h2;
    localparam logic PIO_HRESP_OKAY = 1'b0;

    typedef enum logic [2:0] {
        PIO_REG_NONE,
        PIO_REG_DIR,
        PIO_REG_OUT,
        PIO_REG_PIN,
        PIO_REG_IEN,
        PIO_REG_CTRL,
        PIO_REG_SENSE,
        PIO_REG_FLAG
    } pio_reg_t;

endpackage

/* File: rtl/pio_sync.sv */
// Pad input synchroniser: high-transparent latch followed by a flop.
// Assumes din is the gated Schmitt level of every pin of both ports.
`timescale 1ns/100ps
module pio_sync
    import pio_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Pad side
    input wire logic [PIO_NPINS-1:0] din,
    // Sampled side
    output logic [PIO_NPINS-1:0] sample_q
);

    logic [PIO_NPINS-1:0] latch_q;

    // Transparent while the clock is high
    always_latch begin
        if (hclk) begin
            latch_q <= din;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sample_q <= PIO_RST_PINS;
        end else begin
            sample_q <= latch_q;
        end
    end

endmodule

/* File: rtl/pio_edge.sv */
// External interrupt flag detection on synchronised pin levels.
// Assumes level is already synchronous to hclk; clear is a w1c mask.
`timescale 1ns/100ps
module pio_edge
    import pio_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Sampled pin levels and sense selection
    input wire logic [PIO_NPINS-1:0] level,
    input wire logic [2*PIO_NPINS-1:0] sense,
    // Software clear
    input wire logic [PIO_NPINS-1:0] clr,
    // Sticky flags
    output logic [PIO_NPINS-1:0] flag_q
);

    logic [PIO_NPINS-1:0] prev_q;
    logic primed_q;
    logic [PIO_NPINS-1:0] hit;

    // Edge hits count regardless of the interrupt enable
    always_comb begin
        for (int i = 0; i < PIO_NPINS; i++) begin
            unique case (sense[2*i +: 2])
                PIO_SENSE_LOW: hit[i] = ~level[i];
                PIO_SENSE_ANY: hit[i] = primed_q & (level[i] ^ prev_q[i]);
                PIO_SENSE_FALL: hit[i] = primed_q & prev_q[i] & ~level[i];
                PIO_SENSE_RISE: hit[i] = primed_q & ~prev_q[i] & level[i];
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_q <= PIO_RST_PINS;
            primed_q <= 1'b0;
        end else begin
            prev_q <= level;
            primed_q <= 1'b1;
        end
    end

    // Set wins over clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_q <= PIO_RST_PINS;
        end else begin
            flag_q <= (flag_q & ~clr) | hit;
        end
    end

endmodule

/* File: test/pio_props.sv */
// Checker: pin override and bus timing relations of pio_top.
// Assumes hready is tied to hreadyout.
`timescale 1ns/100ps
module pio_props
    import pio_pkg::*;
(
    // Clock, reset and bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    // Sleep and overrides
    input wire logic sleep_clamp,
    input wire logic [PIO_NPINS-1:0] pullup_override_en,
    input wire logic [PIO_NPINS-1:0] pullup_override_val,
    input wire logic [PIO_NPINS-1:0] dir_override_en,
    input wire logic [PIO_NPINS-1:0] dir_override_val,
    input wire logic [PIO_NPINS-1:0] value_override_en,
    input wire logic [PIO_NPINS-1:0] value_override_val,
    input wire logic [PIO_NPINS-1:0] input_enable_override_en,
    input wire logic [PIO_NPINS-1:0] input_enable_override_val,
    // Pads
    input wire logic [PIO_NPINS-1:0] alt_digital_in,
    input wire logic [PIO_NPINS-1:0] pad_in,
    input wire logic [PIO_NPINS-1:0] pad_out,
    input wire logic [PIO_NPINS-1:0] pad_oe,
    input wire logic [PIO_NPINS-1:0] pad_pullup
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic up_q;
    logic req;
    // Past values usable from the second edge after reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            up_q <= 1'b0;
        end else begin
            up_q <= 1'b1;
        end
    end
    assign req = hsel && hready && htrans == PIO_HTRANS_NONSEQ;
    property p_dir_ovr;
        up_q |-> ((pad_oe ^ $past(dir_override_val)) & $past(dir_override_en)) == '0;
    endproperty
    a_dir_ovr: assert property (p_dir_ovr) else $error("driver ignores override");
    property p_pu_ovr;
        up_q |-> ((pad_pullup ^ $past(pullup_override_val))
            & $past(pullup_override_en)) == '0;
    endproperty
    a_pu_ovr: assert property (p_pu_ovr) else $error("pull-up ignores override");
    property p_val_ovr;
        up_q |-> ((pad_out ^ $past(value_override_val)) & $past(value_override_en)
            & pad_oe) == '0;
    endproperty
    a_val_ovr: assert property (p_val_ovr) else $error("level ignores override");
    property p_gate;
        up_q |-> ((pad_out & ~pad_oe) | (pad_pullup & pad_oe & ~$past(pullup_override_en)
            & ~$past(dir_override_en))) == '0;
    endproperty
    a_gate: assert property (p_gate) else $error("level or pull-up on wrong side");
    property p_ie_ovr;
        ((alt_digital_in ^ (pad_in & input_enable_override_val))
            & input_enable_override_en) == '0;
    endproperty
    a_ie_ovr: assert property (p_ie_ovr) else $error("input enable override lost");
    property p_ie_norm;
        !sleep_clamp |-> ((alt_digital_in ^ pad_in) & ~input_enable_override_en) == '0;
    endproperty
    a_ie_norm: assert property (p_ie_norm) else $error("awake input not passed");
    property p_rd_wait;
        req && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
    property p_wr_now;
        req && hwrite |=> hreadyout;
    endproperty
    a_wr_now: assert property (p_wr_now) else $error("write stalled");
    property p_okay;
        hresp == PIO_HRESP_OKAY;
    endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    property p_reset;
        @(posedge hclk) disable iff (1'b0) !hresetn |-> (pad_oe | pad_out | pad_pullup) == '0;
    endproperty
    a_reset: assert property (p_reset) else $error("pins active in reset");
    c_read: cover property (req && !hwrite);
    c_clamp: cover property (sleep_clamp && |alt_digital_in);
    c_dovr: cover property (|(dir_override_en & dir_override_val));
endmodule

bind pio_top pio_props u_props (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
    .hreadyout, .hresp, .sleep_clamp, .pullup_override_en, .pullup_override_val,
    .dir_override_en, .dir_override_val, .value_override_en, .value_override_val,
    .input_enable_override_en, .input_enable_override_val, .alt_digital_in, .pad_in,
    .pad_out, .pad_oe, .pad_pullup);

/* File: test/pio_periph_model.sv */
// Peripheral model: makes per-pin override signals, syncs its input.
// Assumes the bench sets group, enable, value and toggle after edges.
`timescale 1ns/100ps
module pio_periph_model
    import pio_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bench control
    input wire logic [3:0] grp,
    input wire logic [PIO_NPINS-1:0] en,
    input wire logic [PIO_NPINS-1:0] val,
    input wire logic [PIO_NPINS-1:0] tog,
    // Overrides
    output logic [PIO_NPINS-1:0] pullup_override_en,
    output logic [PIO_NPINS-1:0] pullup_override_val,
    output logic [PIO_NPINS-1:0] dir_override_en,
    output logic [PIO_NPINS-1:0] dir_override_val,
    output logic [PIO_NPINS-1:0] value_override_en,
    output logic [PIO_NPINS-1:0] value_override_val,
    output logic [PIO_NPINS-1:0] toggle_override_en,
    output logic [PIO_NPINS-1:0] input_enable_override_en,
    output logic [PIO_NPINS-1:0] input_enable_override_val,
    // Alternate input
    input wire logic [PIO_NPINS-1:0] alt_digital_in,
    output logic [PIO_NPINS-1:0] di_sync_q
);
    logic [3:0] grp_q;
    logic [PIO_NPINS-1:0] en_q, val_q, tog_q, di_meta_q;
    // Overrides generated inside the peripheral
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            grp_q <= '0;
            en_q <= '0;
            val_q <= '0;
            tog_q <= '0;
        end else begin
            grp_q <= grp;
            en_q <= en;
            val_q <= val;
            tog_q <= tog;
        end
    end
    assign pullup_override_en = grp_q[0] ? en_q : '0;
    assign pullup_override_val = val_q;
    assign dir_override_en = grp_q[1] ? en_q : '0;
    assign dir_override_val = val_q;
    assign value_override_en = grp_q[2] ? en_q : '0;
    assign value_override_val = ~val_q;
    assign toggle_override_en = tog_q;
    assign input_enable_override_en = grp_q[3] ? en_q : '0;
    assign input_enable_override_val = val_q;
    // Own synchroniser for the raw input
    always_ff @(posedge hclk) begin
        di_meta_q <= alt_digital_in;
        di_sync_q <= di_meta_q;
    end
endmodule

/* File: test/pio_tb_top.sv */
// Bench for pio_top: bus tasks, random pin setups, sleep and flag cases.
// Assumes pio_top is the only AHB-Lite slave.
`timescale 1ns/100ps
module pio_tb_top;
    import pio_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, sleep_clamp, global_pullup_disable;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] grp, g;
    logic [31:0] haddr, hwdata, hrdata, seed;
    logic [47:0] x;
    logic [7:0] amap [12];
    logic [PIO_NPINS-1:0] en, val, tog, pad_in, pad_out, pad_oe, pad_pullup, dir, out, e, v;
    logic [PIO_NPINS-1:0] pullup_override_en, pullup_override_val, dir_override_en;
    logic [PIO_NPINS-1:0] dir_override_val, value_override_en, value_override_val;
    logic [PIO_NPINS-1:0] toggle_override_en, input_enable_override_en;
    logic [PIO_NPINS-1:0] input_enable_override_val, alt_digital_in, ext_int_flag;
    int fails, n_tests;
    assign hready = hreadyout;
    pio_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hreadyout, .hrdata, .hresp, .sleep_clamp, .pullup_override_en, .pullup_override_val,
        .dir_override_en, .dir_override_val, .value_override_en, .value_override_val,
        .toggle_override_en, .input_enable_override_en, .input_enable_override_val,
        .alt_digital_in, .ext_int_flag, .pad_in, .pad_out, .pad_oe, .pad_pullup);
    pio_periph_model u_periph (.hclk, .hresetn, .grp, .en, .val, .tog, .pullup_override_en,
        .pullup_override_val, .dir_override_en, .dir_override_val, .value_override_en,
        .value_override_val, .toggle_override_en, .input_enable_override_en,
        .input_enable_override_val, .alt_digital_in, .di_sync_q());
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0000_0000);
    endfunction
    // Expected {oe, out, pull-up} of all pins
    function automatic logic [47:0] pins(input logic [15:0] d, o, input logic p,
        input logic [3:0] gs, input logic [15:0] en_, v_);
        logic [15:0] oe, po, pe, doe, voe;
        doe = gs[1] ? en_ : '0;
        voe = gs[2] ? en_ : '0;
        pe = gs[0] ? en_ : '0;
        oe = (doe & v_) | (~doe & d);
        po = oe & ((voe & ~v_) | (~voe & o));
        return {oe, po, (pe & v_) | (~pe & ~d & o & {16{~p}})};
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_rdy(output logic [31:0] d);
        int k;
        for (k = 0; k < 50; k++) begin
            @(negedge hclk);
            if (hreadyout === 1'b1) break;
        end
        if (k == 50) fails++;
        d = hrdata;
        @(posedge hclk);
    endtask
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= 32'(a);
        hwrite <= wr;
        htrans <= PIO_HTRANS_NONSEQ;
        wait_rdy(d);
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy(d);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] d;
        xfer(1'b1, a, wd, d);
    endtask
    task automatic rdck(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        xfer(1'b0, a, 32'h0000_0000, d);
        check(d, exp);
    endtask
    task automatic settle();
        repeat (3) @(posedge hclk);
        @(negedge hclk);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        hclk = 1'b0;
        forever #(PIO_CLK_PERIOD_NS / 2.0) hclk = ~hclk;
    end
    initial begin
        #(PIO_CLK_PERIOD_NS * 20000);
        fails++;
        report_and_stop();
    end
    initial begin
        #1;
        {hresetn, hsel, hwrite, sleep_clamp, htrans, haddr, hwdata} = '0;
        {grp, en, val, tog, pad_in} = '0;
        hsize = 3'h2;
        seed = 32'h55ab_09ee;
        amap = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24,
            8'h28, 8'h30};
        repeat (5) @(posedge hclk);
        @(negedge hclk);
        check(32'({pad_oe, pad_out} | 32'(pad_pullup)), 32'h0000_0000);
        @(posedge hclk);
        hresetn <= 1'b1;
        foreach (amap[i]) rdck(amap[i], (amap[i] == PIO_OFS_FLAG) ? 32'h0000_FFFF : 32'h0000_0000);
        wr(8'h30, 32'hFFFF_FFFF);
        rdck(8'h30, 32'h0000_0000);
        for (int i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            dir = seed[15:0];
            out = seed[31:16];
            seed = lfsr(seed);
            e = seed[15:0];
            v = seed[31:16];
            seed = lfsr(seed);
            global_pullup_disable = seed[0];
            g = (i < 8) ? 4'h0 : seed[4:1];
            if (i < 2) begin
                dir = '0;
                out = '1;
                global_pullup_disable = i[0];
            end
            wr(PIO_OFS_DIR, 32'(dir[7:0]));
            wr(PIO_PORT_STRIDE + PIO_OFS_DIR, 32'(dir[15:8]));
            wr(PIO_OFS_OUT, 32'(out[7:0]));
            wr(PIO_PORT_STRIDE + PIO_OFS_OUT, 32'(out[15:8]));
            wr(PIO_OFS_CTRL, 32'(global_pullup_disable));
            grp <= g;
            en <= e;
            val <= v;
            pad_in <= seed[31:16];
            settle();
            x = pins(dir, out, global_pullup_disable, g, e, v);
            check(32'(pad_oe), 32'(x[47:32]));
            check(32'(pad_out), 32'(x[31:16]));
            check(32'(pad_pullup), 32'(x[15:0]));
            check(32'(alt_digital_in), 32'(pad_in & (g[3] ? v | ~e : '1)));
            rdck(PIO_OFS_DIR, 32'(dir[7:0]));
            rdck(PIO_PORT_STRIDE + PIO_OFS_PIN, 32'((pad_in & (g[3] ? v | ~e : '1)) >> 8));
        end
        grp <= '0;
        wr(PIO_OFS_OUT, 32'h0000_005A);
        wr(PIO_OFS_PIN, 32'h0000_000F);
        rdck(PIO_OFS_OUT, 32'h0000_0055);
        tog <= 16'h0003;
        @(posedge hclk);
        tog <= '0;
        rdck(PIO_OFS_OUT, 32'h0000_0056);
        pad_in <= '1;
        wr(PIO_OFS_IEN, 32'h0000_00F0);
        wr(PIO_PORT_STRIDE + PIO_OFS_IEN, 32'h0000_00FF);
        wr(PIO_OFS_SENSE, 32'h0000_0027);
        wr(PIO_OFS_FLAG, 32'h0000_FFFF);
        sleep_clamp <= 1'b1;
        settle();
        check(32'(alt_digital_in), 32'h0000_FFF0);
        wr(PIO_OFS_FLAG, 32'h0000_FFFF);
        sleep_clamp <= 1'b0;
        settle();
        check(32'(ext_int_flag), 32'h0000_000B);
        rdck(PIO_OFS_FLAG, 32'h0000_000B);
        report_and_stop();
    end
endmodule
